// ---- design/rcbr_params.svh ----
// offsets, field positions, reset values and timing counts of the regulator and reset block
`ifndef RCBR_PARAMS_SVH
`define RCBR_PARAMS_SVH
`define RCBR_ADDR_REGCTL 12'h000
`define RCBR_ADDR_CAUSE 12'h004
`define RCBR_ADDR_INTSTAT 12'h008
`define RCBR_ADDR_INTMASK 12'h00c
`define RCBR_ADDR_CONFIG 12'h010
`define RCBR_LPWR_BIT 15
`define RCBR_SEL_A_LSB 0
`define RCBR_SEL_B_LSB 2
`define RCBR_SEL_PLL_LSB 4
`define RCBR_REGCTL_RST 16'h0000
`define RCBR_REGCTL_ONES 16'h7fc0
`define RCBR_REGCTL_WMASK 16'h803f
`define RCBR_CAUSE_BO_BIT 1
`define RCBR_INT_BO_BIT 0
`define RCBR_INT_REL_BIT 1
`define RCBR_CFG_OSC_BIT 0
`define RCBR_CFG_PLL_BIT 1
`define RCBR_CFG_XTAL_BIT 2
`define RCBR_CFG_PWRUP0_BIT 3
`define RCBR_CFG_RST 4'h0
`define RCBR_CLK_PERIOD_NS 100
`define RCBR_STARTUP_NS 102400
`define RCBR_PWRUP_NS 1000000
`define RCBR_FSCM_NS 500000
`define RCBR_STARTUP_CYCLES ((`RCBR_STARTUP_NS + `RCBR_CLK_PERIOD_NS - 1) / `RCBR_CLK_PERIOD_NS)
`define RCBR_PWRUP_CYCLES ((`RCBR_PWRUP_NS + `RCBR_CLK_PERIOD_NS - 1) / `RCBR_CLK_PERIOD_NS)
`define RCBR_FSCM_CYCLES ((`RCBR_FSCM_NS + `RCBR_CLK_PERIOD_NS - 1) / `RCBR_CLK_PERIOD_NS)
`endif

// ---- design/rcbr_pkg.sv ----
// types of the regulator and reset block
package rcbr_pkg;
  typedef enum logic [2:0]
  {
    st_run = 3'b001,
    st_brown = 3'b010,
    st_wait = 3'b100
  } rcbr_state_e;
  typedef logic [15:0] rcbr_cnt_t;
endpackage : rcbr_pkg

// ---- design/rcbr_sync3.sv ----
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module rcbr_sync3
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic pin_in,
  output logic level_out
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      lvl_q <= 1'b0;
    end
    else
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // change counts only once stages two and three agree
      if (s2_q == s3_q)
      begin
        lvl_q <= s3_q;
      end
    end
  end

  assign level_out = lvl_q;
endmodule : rcbr_sync3
`default_nettype wire

// ---- design/rcbr_delay.sv ----
// loadable down-counter; done while the count is zero
`timescale 1ns/1ps
`default_nettype none
module rcbr_delay
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire rcbr_pkg::rcbr_cnt_t load_in,
  output logic done_out
);
  rcbr_pkg::rcbr_cnt_t cnt_q;

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      cnt_q <= 16'h0000;
    end
    else if (start_in)
    begin
      cnt_q <= load_in;
    end
    else if (cnt_q != 16'h0000)
    begin
      cnt_q <= cnt_q - 16'h0001;
    end
  end

  assign done_out = (cnt_q == 16'h0000);
endmodule : rcbr_delay
`default_nettype wire

// ---- design/rcbr_top.sv ----
// regulator control register and supply-drop reset sequencer with apb slave
//
// Notes on behaviour
// - low_power_regulator_enable at bit 15 puts all regulators in low power when one.
// - three two-bit selects at bits 5-4, 3-2, 1-0 each steer only their own regulator.
// - bits 14-6 of regulator_control read as one.
// - a supply drop produces a reset that resets the whole device.
// - on a supply-drop reset the clock source follows the stored oscillator settings.
// - with an oscillator mode set the startup timer runs and the clock stays gated till it ends.
// - with the pll in use the clock stays held until pll lock reads one.
// - the power-up delay runs alongside clock start-up before internal reset is released.
// - with zero power-up delay and a crystal the fail-safe monitor delay is used instead.
// - a supply-drop reset sets the supply_drop_reset flag in reset_cause_register.
// - supply-drop detection stays active in sleep and idle and resets on every drop; the pin filter ignores a drop seen in only one clock sample.
`include "rcbr_params.svh"
`timescale 1ns/1ps
`default_nettype none
module rcbr_top
#(
  parameter logic [15:0] PWRUP_CYCLES = 16'(`RCBR_PWRUP_CYCLES),
  parameter logic [15:0] FSCM_CYCLES = 16'(`RCBR_FSCM_CYCLES)
)
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic supply_low_in,
  input wire logic pll_lock_in,
  output logic low_power_regulator_enable_out,
  output logic [1:0] core_regulator_a_voltage_sel_out,
  output logic [1:0] core_regulator_b_voltage_sel_out,
  output logic [1:0] pll_regulator_voltage_sel_out,
  output logic [8:0] regulator_level_out,
  output logic device_reset_out,
  output logic clock_hold_out,
  output logic irq_out
);
  localparam logic [15:0] STARTUP_CYCLES = 16'(`RCBR_STARTUP_CYCLES);

  rcbr_pkg::rcbr_state_e state_q;
  rcbr_pkg::rcbr_state_e state_d;
  logic [15:0] regctl_q;
  logic [3:0] cfg_q;
  logic bo_flag_q;
  logic [1:0] stat_q;
  logic [1:0] mask_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic rst_q;
  logic hold_q;
  logic [8:0] level_q;
  logic low_s;
  logic lock_s;
  logic start_done;
  logic rel_done;

  // apb decode
  wire setup = psel_in && !penable_in;
  wire acc = psel_in && penable_in;
  wire wr = acc && pwrite_in;
  wire hit_regctl = (paddr_in == `RCBR_ADDR_REGCTL);
  wire hit_cause = (paddr_in == `RCBR_ADDR_CAUSE);
  wire hit_stat = (paddr_in == `RCBR_ADDR_INTSTAT);
  wire hit_mask = (paddr_in == `RCBR_ADDR_INTMASK);
  wire hit_cfg = (paddr_in == `RCBR_ADDR_CONFIG);
  wire hit_any = hit_regctl || hit_cause || hit_stat || hit_mask || hit_cfg;
  wire wr_regctl = wr && hit_regctl;
  wire wr_cause = wr && hit_cause;
  wire wr_mask = wr && hit_mask;
  wire wr_cfg = wr && hit_cfg;
  wire rd_stat = acc && !pwrite_in && hit_stat;
  wire [15:0] regctl_rd = regctl_q | `RCBR_REGCTL_ONES;
  wire [31:0] rd_mux =
    hit_regctl ? {16'h0000, regctl_rd} :
    hit_cause ? {30'h0000_0000, bo_flag_q, 1'b0} :
    hit_stat ? {30'h0000_0000, stat_q} :
    hit_mask ? {30'h0000_0000, mask_q} :
    hit_cfg ? {28'h000_0000, cfg_q} : 32'h0000_0000;

  // stored oscillator settings
  wire cfg_osc = cfg_q[`RCBR_CFG_OSC_BIT];
  wire cfg_pll = cfg_q[`RCBR_CFG_PLL_BIT];
  wire cfg_xtal = cfg_q[`RCBR_CFG_XTAL_BIT];
  wire cfg_pwrup0 = cfg_q[`RCBR_CFG_PWRUP0_BIT];

  // sequencer terms
  wire bo_enter = low_s && (state_q != rcbr_pkg::st_brown);
  wire seq_start = (state_q == rcbr_pkg::st_brown) && !low_s;
  wire start_ok = !cfg_osc || start_done;
  wire lock_ok = !cfg_pll || lock_s;
  wire clk_ok = start_ok && lock_ok;
  wire rel_event = (state_q == rcbr_pkg::st_wait) && !low_s && clk_ok && rel_done;
  // crystal with zero power-up delay swaps in the monitor delay
  wire [15:0] rel_load = cfg_pwrup0 ? (cfg_xtal ? FSCM_CYCLES : 16'h0000) : PWRUP_CYCLES;
  wire [15:0] start_load = cfg_osc ? STARTUP_CYCLES : 16'h0000;
  wire [1:0] ev = {rel_event, bo_enter};
  wire [1:0] stat_clr = rd_stat ? prdata_q[1:0] : 2'b00;

  rcbr_sync3 u_sync_low
  (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .pin_in(supply_low_in),
    .level_out(low_s)
  );

  rcbr_sync3 u_sync_lock
  (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .pin_in(pll_lock_in),
    .level_out(lock_s)
  );

  rcbr_delay u_startup
  (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .start_in(seq_start),
    .load_in(start_load),
    .done_out(start_done)
  );

  rcbr_delay u_rel
  (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .start_in(seq_start),
    .load_in(rel_load),
    .done_out(rel_done)
  );

  // sequencer next state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      rcbr_pkg::st_run:
      begin
        if (low_s)
        begin
          state_d = rcbr_pkg::st_brown;
        end
      end
      rcbr_pkg::st_brown:
      begin
        if (!low_s)
        begin
          state_d = rcbr_pkg::st_wait;
        end
      end
      rcbr_pkg::st_wait:
      begin
        if (low_s)
        begin
          state_d = rcbr_pkg::st_brown;
        end
        else if (clk_ok && rel_done)
        begin
          state_d = rcbr_pkg::st_run;
        end
      end
      default:
      begin
        state_d = rcbr_pkg::st_brown;
      end
    endcase
  end

  wire rst_d = (state_d != rcbr_pkg::st_run);
  // timers load on the entry edge; their stale done flags must not free the clock
  wire hold_d = (state_d == rcbr_pkg::st_brown) ||
                ((state_d == rcbr_pkg::st_wait) && (seq_start || !clk_ok));

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      state_q <= rcbr_pkg::st_run;
      rst_q <= 1'b0;
      hold_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      rst_q <= rst_d;
      hold_q <= hold_d;
    end
  end

  // regulator control; the device reset clears it
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in || bo_enter)
    begin
      regctl_q <= `RCBR_REGCTL_RST;
    end
    else if (wr_regctl)
    begin
      regctl_q <= pwdata_in[15:0] & `RCBR_REGCTL_WMASK;
    end
  end

  // set wins over clear so no drop is lost
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      bo_flag_q <= 1'b0;
    end
    else if (bo_enter)
    begin
      bo_flag_q <= 1'b1;
    end
    else if (wr_cause && pwdata_in[`RCBR_CAUSE_BO_BIT])
    begin
      bo_flag_q <= 1'b0;
    end
  end

  // oscillator settings and mask survive the device reset
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      cfg_q <= `RCBR_CFG_RST;
      mask_q <= 2'b00;
    end
    else
    begin
      if (wr_cfg)
      begin
        cfg_q <= pwdata_in[3:0];
      end
      if (wr_mask)
      begin
        mask_q <= pwdata_in[1:0];
      end
    end
  end

  // read clears only the bits that were returned
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      stat_q <= 2'b00;
    end
    else
    begin
      stat_q <= (stat_q & ~stat_clr) | ev;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else if (setup)
    begin
      prdata_q <= pwrite_in ? 32'h0000_0000 : rd_mux;
      pslverr_q <= !hit_any;
    end
  end

  // per-regulator level decode, one-hot {1.2 V, 1.0 V, 0.8 V}
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_reg
      wire [1:0] sel = regctl_q[2*gi+1:2*gi];
      logic [2:0] lvl_q;
      always_ff @(posedge clock_in)
      begin
        if (!rst_n_in)
        begin
          lvl_q <= 3'b100;
        end
        else
        begin
          lvl_q <= (sel == 2'b01) ? 3'b001 :
                   (sel == 2'b10) ? 3'b010 : 3'b100;
        end
      end
      assign level_q[3*gi+2:3*gi] = lvl_q;
    end
  endgenerate

  assign prdata_out = prdata_q;
  assign pready_out = 1'b1;
  assign pslverr_out = pslverr_q && acc;
  assign low_power_regulator_enable_out = regctl_q[`RCBR_LPWR_BIT];
  assign core_regulator_a_voltage_sel_out = regctl_q[`RCBR_SEL_A_LSB+1:`RCBR_SEL_A_LSB];
  assign core_regulator_b_voltage_sel_out = regctl_q[`RCBR_SEL_B_LSB+1:`RCBR_SEL_B_LSB];
  assign pll_regulator_voltage_sel_out = regctl_q[`RCBR_SEL_PLL_LSB+1:`RCBR_SEL_PLL_LSB];
  assign regulator_level_out = level_q;
  assign device_reset_out = rst_q;
  assign clock_hold_out = hold_q;
  assign irq_out = |(stat_q & mask_q);

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);

  property p_lpwr;
    wr_regctl && !bo_enter |=> low_power_regulator_enable_out == $past(pwdata_in[15]);
  endproperty
  a_lpwr: assert property (p_lpwr) else $error("low power enable missed write");

  property p_dec;
    (core_regulator_b_voltage_sel_out == 2'b10) |=> regulator_level_out[5:3] == 3'b010;
  endproperty
  a_dec: assert property (p_dec) else $error("select 10 not decoded to 1.0 V");

  property p_sel;
    wr_regctl && !bo_enter |=> core_regulator_a_voltage_sel_out == $past(pwdata_in[1:0]) &&
      pll_regulator_voltage_sel_out == $past(pwdata_in[5:4]);
  endproperty
  a_sel: assert property (p_sel) else $error("voltage select not stored");

  property p_ones;
    setup && !pwrite_in && hit_regctl |=> prdata_out[14:6] == 9'h1ff;
  endproperty
  a_ones: assert property (p_ones) else $error("unused bits not read as one");

  property p_bor;
    $rose(low_s) |=> device_reset_out && clock_hold_out;
  endproperty
  a_bor: assert property (p_bor) else $error("drop did not assert reset");

  property p_startup;
    $fell(clock_hold_out) |-> $past(!cfg_osc || start_done);
  endproperty
  a_startup: assert property (p_startup) else $error("clock released before startup timer");

  property p_lock;
    $fell(clock_hold_out) |-> $past(!cfg_pll || lock_s);
  endproperty
  a_lock: assert property (p_lock) else $error("clock released before pll lock");

  property p_rel;
    $fell(device_reset_out) |-> $past(rel_done) && !clock_hold_out;
  endproperty
  a_rel: assert property (p_rel) else $error("reset released early");

  property p_flag;
    $rose(low_s) |=> bo_flag_q;
  endproperty
  a_flag: assert property (p_flag) else $error("drop flag not set");

  property p_sticky;
    bo_flag_q && !(wr_cause && pwdata_in[1]) |=> bo_flag_q;
  endproperty
  a_sticky: assert property (p_sticky) else $error("drop flag lost");
endmodule : rcbr_top
`default_nettype wire

// ---- test/rcbr_supply_model.sv ----
// analog supply monitor and pll model for the regulator and reset block
`timescale 1ns/1ps
`default_nettype none
module rcbr_supply_model
#(
  parameter int LOCK_DLY = 100
)
(
  input wire logic clock_in,
  input wire logic drop_in,
  output logic supply_low_out,
  output logic pll_lock_out
);
  logic [15:0] cnt_q = 16'h0000;
  // monitor output follows the supply, no hysteresis modelled
  assign supply_low_out = drop_in;
  // pll loses lock on a sag and relocks a while after the supply recovers
  always_ff @(posedge clock_in)
  begin
    if (drop_in)
      cnt_q <= 16'h0000;
    else if (cnt_q != 16'(LOCK_DLY))
      cnt_q <= cnt_q + 16'h0001;
  end
  assign pll_lock_out = (cnt_q == 16'(LOCK_DLY));
endmodule : rcbr_supply_model
`default_nettype wire

// ---- test/regulator_ctrl_brownout_reset_test.sv ----
// apb register and supply-drop sequence tests of the regulator and reset block
`include "rcbr_params.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin bad_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module regulator_ctrl_brownout_reset_test;
  logic clock_in = 0, rst_n_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0, drop = 0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0000_0000, prdata_out, rd;
  logic pready_out, pslverr_out, supply_low_in, pll_lock_in, lp, rst_o, hold, irq_out, err, lk;
  logic [1:0] sa, sb, sp;
  logic [8:0] lvl;
  logic [3:0] cfg_t [5] = '{4'h0, 4'h1, 4'h2, 4'hc, 4'h8};
  int hmin [5] = '{0, 1024, 100, 0, 0};
  int rmin [5] = '{20, 1024, 100, 40, 0};
  int bad_count = 0, checks = 0, th, tr;
  always #50 clock_in = ~clock_in;
  rcbr_top #(.PWRUP_CYCLES(16'h0014), .FSCM_CYCLES(16'h0028)) u_dut
  (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .supply_low_in(supply_low_in), .pll_lock_in(pll_lock_in),
    .low_power_regulator_enable_out(lp), .core_regulator_a_voltage_sel_out(sa),
    .core_regulator_b_voltage_sel_out(sb), .pll_regulator_voltage_sel_out(sp),
    .regulator_level_out(lvl), .device_reset_out(rst_o), .clock_hold_out(hold),
    .irq_out(irq_out)
  );
  rcbr_supply_model #(.LOCK_DLY(100)) u_sup
  (
    .clock_in(clock_in), .drop_in(drop), .supply_low_out(supply_low_in),
    .pll_lock_out(pll_lock_in)
  );
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_in);
    psel_in <= 1;
    penable_in <= 0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clock_in);
    penable_in <= 1;
    do
    begin
      @(posedge clock_in);
    end
    while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 0;
    penable_in <= 0;
  endtask : apb
  task automatic settle();
    repeat (2) @(posedge clock_in);
    #1;
  endtask : settle
  function automatic logic [2:0] dec(input logic [1:0] c);
    case (c)
      2'b01: dec = 3'b001;
      2'b10: dec = 3'b010;
      default: dec = 3'b100;
    endcase
  endfunction : dec
  // pin held high until the reset shows and ten cycles more, then released and timed
  task automatic brown(output int h, output int r);
    int n;
    drop <= 1;
    for (n = 0; n < 20 && rst_o !== 1'b1; n++) @(posedge clock_in);
    repeat (10) @(posedge clock_in);
    #1;
    `CHK(rst_o, 1'b1)
    `CHK(hold, 1'b1)
    drop <= 0;
    h = -1;
    for (n = 0; n < 2000 && rst_o !== 1'b0; n++)
    begin
      @(posedge clock_in);
      #1;
      if (h < 0 && hold === 1'b0)
      begin
        h = n;
        lk = pll_lock_in;
      end
    end
    r = n;
  endtask : brown
  task results();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results
  initial
  begin
    #1_000_000;
    bad_count++;
    results();
  end
  initial
  begin
    repeat (2) @(posedge clock_in);
    rst_n_in <= 1;
    settle();
    `CHK(lvl, 9'h124)
    apb(0, `RCBR_ADDR_REGCTL, 32'h0000_0000);
    `CHK(rd, 32'h0000_7fc0)
    apb(0, `RCBR_ADDR_CAUSE, 32'h0000_0000);
    `CHK(rd[1], 1'b0)
    // clock already slow and peripherals idle in this bench
    apb(1, `RCBR_ADDR_REGCTL, 32'h0000_ffff);
    apb(0, `RCBR_ADDR_REGCTL, 32'h0000_0000);
    `CHK(rd, 32'h0000_ffff)
    `CHK(lp, 1'b1)
    apb(1, `RCBR_ADDR_REGCTL, 32'h0000_0000);
    settle();
    `CHK(lp, 1'b0)
    $display("register test done");
    for (int c = 0; c < 4; c++)
    begin
      apb(1, `RCBR_ADDR_REGCTL, {26'h0, 2'(c + 2), 2'(c + 1), 2'(c)});
      settle();
      `CHK(sa, 2'(c))
      `CHK(sb, 2'(c + 1))
      `CHK(sp, 2'(c + 2))
      `CHK(lvl, {dec(2'(c + 2)), dec(2'(c + 1)), dec(2'(c))})
    end
    apb(0, 12'h014, 32'h0000_0000);
    `CHK(err, 1'b1)
    `CHK(rd, 32'h0000_0000)
    $display("decode test done");
    apb(1, `RCBR_ADDR_REGCTL, 32'h0000_ffff);
    apb(1, `RCBR_ADDR_INTMASK, 32'h0000_0000);
    for (int i = 0; i < 5; i++)
    begin
      apb(1, `RCBR_ADDR_CONFIG, {28'h0, cfg_t[i]});
      brown(th, tr);
      // small slack covers the pin synchronisers
      `CHK(th >= hmin[i] && th <= hmin[i] + 12, 1'b1)
      `CHK(tr >= rmin[i] && tr <= rmin[i] + 12, 1'b1)
      if (cfg_t[i][1])
        `CHK(lk, 1'b1)
      apb(0, `RCBR_ADDR_CAUSE, 32'h0000_0000);
      `CHK(rd[1], 1'b1)
      if (i == 0)
      begin
        apb(0, `RCBR_ADDR_REGCTL, 32'h0000_0000);
        `CHK(rd, 32'h0000_7fc0)
        settle();
        `CHK(irq_out, 1'b0)
        apb(1, `RCBR_ADDR_INTMASK, 32'h0000_0003);
      end
      settle();
      `CHK(irq_out, 1'b1)
      apb(0, `RCBR_ADDR_INTSTAT, 32'h0000_0000);
      `CHK(rd, 32'h0000_0003)
      settle();
      `CHK(irq_out, 1'b0)
    end
    apb(1, `RCBR_ADDR_CAUSE, 32'h0000_0000);
    apb(0, `RCBR_ADDR_CAUSE, 32'h0000_0000);
    `CHK(rd[1], 1'b1)
    apb(1, `RCBR_ADDR_CAUSE, 32'h0000_0002);
    apb(0, `RCBR_ADDR_CAUSE, 32'h0000_0000);
    `CHK(rd[1], 1'b0)
    $display("supply drop test done");
    results();
  end
endmodule : regulator_ctrl_brownout_reset_test
`default_nettype wire
